// file: common/icache_pkg.sv
package icache_pkg;

  // ---------------------------------------------------------------
  // address split and line geometry
  // ---------------------------------------------------------------
  localparam int OFFSET_W = 5;            // byte offset inside a line
  localparam int LINE_BYTES = 32;
  localparam int WORD_SEL_W = 3;          // word inside a line
  localparam int WORDS_PER_LINE = 8;
  localparam int WORD_W = 32;
  localparam int BUS_ADDR_W = 32;
  localparam int MAX_ADDR_W = 31;         // widest instruction byte address

  // ---------------------------------------------------------------
  // build-time limits
  // ---------------------------------------------------------------
  localparam int CACHE_MIN_BYTES = 512;
  localparam int CACHE_MAX_BYTES = 65536;
  localparam int CACHE_DEF_BYTES = 4096;
  localparam int MAX_TCM = 4;

  // ---------------------------------------------------------------
  // timing and reset values
  // ---------------------------------------------------------------
  localparam int TCM_READ_LAT = 1;        // cycles from sampled read to data
  localparam logic [3:0] FILL_LEN_LINE = 4'h8;
  localparam logic [3:0] FILL_LEN_WORD = 4'h1;
  localparam logic [WORD_W-1:0] DATA_RST = 32'h0000_0000;

  // fetch sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_FILL,
    ST_TCM_RD,
    ST_TCM_WAIT
  } fetch_state_e;

endpackage

// file: core/icache_store.sv
`timescale 1ns/1ps

module icache_store
  import icache_pkg::*;
#(
  parameter int IDX_W = 7,
  parameter int TAG_W = 19
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // lookup read, answered one cycle later
  input wire logic i_rd_en,
  input wire logic [IDX_W-1:0] i_rd_idx,
  input wire logic [WORD_SEL_W-1:0] i_rd_word,
  output logic [WORD_W-1:0] o_rd_data,
  output logic [TAG_W-1:0] o_rd_tag,
  output logic o_rd_valid,
  // word write during a fill
  input wire logic i_wr_en,
  input wire logic [IDX_W-1:0] i_wr_idx,
  input wire logic [WORD_SEL_W-1:0] i_wr_word,
  input wire logic [WORD_W-1:0] i_wr_data,
  // tag and valid write
  input wire logic i_tag_we,
  input wire logic [IDX_W-1:0] i_tag_idx,
  input wire logic i_tag_set,
  input wire logic [TAG_W-1:0] i_tag
);

  localparam int LINES = 1 << IDX_W;

  logic [WORD_W-1:0] data_mem [LINES*WORDS_PER_LINE];
  logic [TAG_W-1:0] tag_mem [LINES];
  logic [LINES-1:0] valid_ff;
  logic [LINES-1:0] nxt_valid;

  // ---------------------------------------------------------------
  // valid bits: the only state that must be cleared by reset
  // ---------------------------------------------------------------
  always_comb begin
    nxt_valid = valid_ff;
    if (i_tag_we) begin
      nxt_valid[i_tag_idx] = i_tag_set;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      valid_ff <= '0;
    end else begin
      valid_ff <= nxt_valid;
    end
  end

  // arrays carry no reset so they map onto block memory
  always_ff @(posedge i_clk_sys) begin
    if (i_wr_en) begin
      data_mem[{i_wr_idx, i_wr_word}] <= i_wr_data;
    end
    if (i_tag_we) begin
      tag_mem[i_tag_idx] <= i_tag;
    end
    if (i_rd_en) begin
      o_rd_data <= data_mem[{i_rd_idx, i_rd_word}];
      o_rd_tag <= tag_mem[i_rd_idx];
      o_rd_valid <= valid_ff[i_rd_idx];
    end
  end

endmodule // icache_store

// file: core/ifetch_mem.sv
`timescale 1ns/1ps

// What this block does
// - cache is direct mapped: one possible line per address
// - cache capacity is a build parameter from 512 bytes to 64 KB
// - a fill reads the whole line, one read per cycle, critical word first
// - address splits into 5-bit offset, capacity-sized line index, tag
// - tag width follows capacity and address width; addresses at most 31 bits
// - at most 2 GB addressed; address bit 31 always driven zero
// - instruction master optional, but rejected without any tightly-coupled port
// - cache optional, only when a tightly-coupled port exists
// - master is pipelined: new reads issue before earlier data returns
// - data master port exists in every build
// - zero to four tightly-coupled ports, each its own read bit and data slice, one shared address
// - fetch address decoded against spans, fetched through matching port
// - tightly-coupled fetches never look up or fill the cache
// - line init and flush leave tightly-coupled spans untouched

module ifetch_mem
  import icache_pkg::*;
#(
  parameter int ADDR_W = MAX_ADDR_W,
  parameter int CACHE_BYTES = CACHE_DEF_BYTES,
  parameter bit HAS_ICACHE = 1'b1,
  parameter bit HAS_IMASTER = 1'b1,
  parameter int NUM_TCM = 0,
  parameter logic [MAX_TCM*BUS_ADDR_W-1:0] TCM_BASE = '0,
  parameter logic [MAX_TCM*BUS_ADDR_W-1:0] TCM_SPAN = '0
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // fetch port from the core
  input wire logic i_fetch_req,
  input wire logic [ADDR_W-1:0] i_fetch_addr,
  output logic o_fetch_ready,
  output logic o_fetch_valid,
  output logic o_fetch_err,
  output logic [WORD_W-1:0] o_fetch_data,
  // line maintenance from the core
  input wire logic i_line_init,
  input wire logic i_line_flush,
  input wire logic [ADDR_W-1:0] i_maint_addr,
  output logic o_maint_done,
  // pipelined instruction master
  output logic o_im_read,
  output logic [BUS_ADDR_W-1:0] o_im_address,
  input wire logic i_im_waitrequest,
  input wire logic i_im_readdatavalid,
  input wire logic [WORD_W-1:0] i_im_readdata,
  // tightly-coupled instruction ports, one read bit and data slice each, one shared address
  output logic [MAX_TCM-1:0] o_tcm_read,
  output logic [BUS_ADDR_W-1:0] o_tcm_address,
  input wire logic [MAX_TCM*WORD_W-1:0] i_tcm_readdata,
  // data-side address from the core and the data master address
  input wire logic [BUS_ADDR_W-1:0] i_dm_addr,
  output logic [BUS_ADDR_W-1:0] o_dm_address
);

  // ---------------------------------------------------------------
  // geometry and build checks
  // ---------------------------------------------------------------
  localparam int IDX_W = $clog2(CACHE_BYTES / LINE_BYTES);
  localparam int TAG_W = ADDR_W - IDX_W - OFFSET_W;
  localparam int TOP_W = BUS_ADDR_W - ADDR_W;
  localparam logic [3:0] FILL_LEN = HAS_ICACHE ? FILL_LEN_LINE : FILL_LEN_WORD;

  if (CACHE_BYTES < CACHE_MIN_BYTES || CACHE_BYTES > CACHE_MAX_BYTES ||
      (CACHE_BYTES & (CACHE_BYTES - 1)) != 0) begin : g_bad_size
    $error("cache size out of range or not a power of two");
  end
  if (ADDR_W > MAX_ADDR_W || TAG_W < 1) begin : g_bad_addr
    $error("address width too wide or leaves no tag");
  end
  if (NUM_TCM < 0 || NUM_TCM > MAX_TCM) begin : g_bad_tcm
    $error("tightly-coupled port count out of range");
  end
  if (!HAS_IMASTER && NUM_TCM == 0) begin : g_bad_master
    $error("no instruction master and no tightly-coupled port");
  end
  if (!HAS_ICACHE && NUM_TCM == 0) begin : g_bad_cache
    $error("no instruction cache and no tightly-coupled port");
  end
  if (HAS_ICACHE && !HAS_IMASTER) begin : g_bad_fill
    $error("cache needs the instruction master to fill");
  end

  // ---------------------------------------------------------------
  // span decode, two comparator pairs per port: fetch and maintenance
  // ---------------------------------------------------------------
  logic [MAX_TCM-1:0] fetch_hit;
  logic [MAX_TCM-1:0] maint_hit;

  for (genvar t = 0; t < MAX_TCM; t++) begin : g_span
    localparam logic [BUS_ADDR_W-1:0] BASE = TCM_BASE[t*BUS_ADDR_W +: BUS_ADDR_W];
    localparam logic [BUS_ADDR_W-1:0] SPAN = TCM_SPAN[t*BUS_ADDR_W +: BUS_ADDR_W];
    logic [BUS_ADDR_W-1:0] fa;
    logic [BUS_ADDR_W-1:0] ma;
    assign fa = {{TOP_W{1'b0}}, i_fetch_addr};
    assign ma = {{TOP_W{1'b0}}, i_maint_addr};
    // offsets compared so a span ending at the top cannot wrap
    assign fetch_hit[t] = (t < NUM_TCM) && fa >= BASE && (fa - BASE) < SPAN;
    assign maint_hit[t] = (t < NUM_TCM) && ma >= BASE && (ma - BASE) < SPAN;
  end

  logic [1:0] fetch_sel;
  always_comb begin
    fetch_sel = 2'h0;
    for (int t = MAX_TCM - 1; t >= 0; t--) begin
      if (fetch_hit[t]) begin
        fetch_sel = t[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fetch_state_e state_ff, nxt_state;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [1:0] sel_ff, nxt_sel;
  logic [3:0] iss_ff, nxt_iss;
  logic [3:0] rsp_ff, nxt_rsp;
  logic ready_ff, nxt_ready;
  logic valid_ff, nxt_valid;
  logic err_ff, nxt_err;
  logic [WORD_W-1:0] data_ff, nxt_data;
  logic done_ff, nxt_done;
  logic im_read_ff, nxt_im_read;
  logic [WORD_SEL_W-1:0] im_word_ff, nxt_im_word;
  logic [MAX_TCM-1:0] tcm_read_ff, nxt_tcm_read;
  logic [BUS_ADDR_W-1:0] tcm_addr_ff, nxt_tcm_addr;
  logic [BUS_ADDR_W-1:0] dm_addr_ff, nxt_dm_addr;

  // store control
  logic rd_en;
  logic wr_en;
  logic tag_we;
  logic tag_set;
  logic [IDX_W-1:0] tag_idx;
  logic [WORD_W-1:0] rd_data;
  logic [TAG_W-1:0] rd_tag;
  logic rd_valid;

  // address fields of the fetch in flight
  logic [IDX_W-1:0] line_idx;
  logic [TAG_W-1:0] line_tag;
  logic [WORD_SEL_W-1:0] crit_word;
  logic [WORD_SEL_W-1:0] fill_word;
  logic hit;

  assign line_idx = addr_ff[OFFSET_W +: IDX_W];
  assign line_tag = addr_ff[ADDR_W-1 -: TAG_W];
  assign crit_word = addr_ff[2 +: WORD_SEL_W];
  assign fill_word = crit_word + rsp_ff[WORD_SEL_W-1:0]; // wraps inside the line
  assign hit = rd_valid && (rd_tag == line_tag);

  // ---------------------------------------------------------------
  // fetch sequencer: next values
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_sel = sel_ff;
    nxt_iss = iss_ff;
    nxt_rsp = rsp_ff;
    nxt_ready = 1'b0;
    nxt_valid = 1'b0;
    nxt_err = 1'b0;
    nxt_data = data_ff;
    nxt_done = 1'b0;
    nxt_im_read = im_read_ff;
    nxt_im_word = im_word_ff;
    nxt_tcm_read = '0;
    nxt_tcm_addr = tcm_addr_ff;
    nxt_dm_addr = {1'b0, i_dm_addr[BUS_ADDR_W-2:0]};
    rd_en = 1'b0;
    wr_en = 1'b0;
    tag_we = 1'b0;
    tag_set = 1'b0;
    tag_idx = line_idx;
    case (state_ff)
      ST_IDLE: begin
        nxt_ready = 1'b1;
        if (ready_ff && i_fetch_req) begin
          nxt_ready = 1'b0;
          nxt_addr = i_fetch_addr;
          if (|fetch_hit) begin
            // cache is neither looked up nor filled here
            nxt_sel = fetch_sel;
            nxt_tcm_read[fetch_sel] = 1'b1;
            nxt_tcm_addr = {{TOP_W{1'b0}}, i_fetch_addr};
            nxt_state = ST_TCM_RD;
          end else if (HAS_ICACHE) begin
            rd_en = 1'b1;
            nxt_state = ST_LOOKUP;
          end else if (HAS_IMASTER) begin
            nxt_iss = 4'h0;
            nxt_rsp = 4'h0;
            nxt_im_read = 1'b1;
            nxt_im_word = i_fetch_addr[2 +: WORD_SEL_W];
            nxt_state = ST_FILL;
          end else begin
            // nothing serves this address: answer with an error
            nxt_valid = 1'b1;
            nxt_err = 1'b1;
            nxt_ready = 1'b1;
          end
        end else if (ready_ff && (i_line_init || i_line_flush)) begin
          tag_idx = i_maint_addr[OFFSET_W +: IDX_W];
          tag_we = HAS_ICACHE && !(|maint_hit);
          nxt_done = 1'b1;
        end
      end
      ST_LOOKUP: begin
        if (hit) begin
          nxt_valid = 1'b1;
          nxt_data = rd_data;
          nxt_ready = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          // drop the old line first so a partial fill never hits
          tag_we = 1'b1;
          nxt_iss = 4'h0;
          nxt_rsp = 4'h0;
          nxt_im_read = 1'b1;
          nxt_im_word = crit_word;
          nxt_state = ST_FILL;
        end
      end
      ST_FILL: begin
        // issue side runs regardless of returning data
        if (im_read_ff && !i_im_waitrequest) begin
          nxt_iss = iss_ff + 4'h1;
          nxt_im_word = im_word_ff + 3'h1;
          if (iss_ff + 4'h1 == FILL_LEN) begin
            nxt_im_read = 1'b0;
          end
        end
        if (i_im_readdatavalid) begin
          wr_en = HAS_ICACHE;
          nxt_rsp = rsp_ff + 4'h1;
          if (rsp_ff == 4'h0) begin
            nxt_valid = 1'b1;
            nxt_data = i_im_readdata;
          end
          if (rsp_ff + 4'h1 == FILL_LEN) begin
            tag_we = HAS_ICACHE;
            tag_set = 1'b1;
            nxt_ready = 1'b1;
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_TCM_RD: begin
        nxt_state = ST_TCM_WAIT;
      end
      ST_TCM_WAIT: begin
        nxt_valid = 1'b1;
        nxt_data = i_tcm_readdata[sel_ff*WORD_W +: WORD_W];
        nxt_ready = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // fetch sequencer: registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
      addr_ff <= '0;
      sel_ff <= 2'h0;
      iss_ff <= 4'h0;
      rsp_ff <= 4'h0;
      ready_ff <= 1'b0;
      valid_ff <= 1'b0;
      err_ff <= 1'b0;
      data_ff <= DATA_RST;
      done_ff <= 1'b0;
      im_read_ff <= 1'b0;
      im_word_ff <= '0;
      tcm_read_ff <= '0;
      tcm_addr_ff <= '0;
      dm_addr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      sel_ff <= nxt_sel;
      iss_ff <= nxt_iss;
      rsp_ff <= nxt_rsp;
      ready_ff <= nxt_ready;
      valid_ff <= nxt_valid;
      err_ff <= nxt_err;
      data_ff <= nxt_data;
      done_ff <= nxt_done;
      im_read_ff <= nxt_im_read;
      im_word_ff <= nxt_im_word;
      tcm_read_ff <= nxt_tcm_read;
      tcm_addr_ff <= nxt_tcm_addr;
      dm_addr_ff <= nxt_dm_addr;
    end
  end

  // ---------------------------------------------------------------
  // line store, present only with a cache
  // ---------------------------------------------------------------
  if (HAS_ICACHE) begin : g_store
    icache_store #(.IDX_W(IDX_W), .TAG_W(TAG_W)) u_store (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_rd_en(rd_en),
      .i_rd_idx(nxt_addr[OFFSET_W +: IDX_W]),
      .i_rd_word(nxt_addr[2 +: WORD_SEL_W]),
      .o_rd_data(rd_data),
      .o_rd_tag(rd_tag),
      .o_rd_valid(rd_valid),
      .i_wr_en(wr_en),
      .i_wr_idx(line_idx),
      .i_wr_word(fill_word),
      .i_wr_data(i_im_readdata),
      .i_tag_we(tag_we),
      .i_tag_idx(tag_idx),
      .i_tag_set(tag_set),
      .i_tag(line_tag)
    );
  end else begin : g_no_store
    assign rd_data = DATA_RST;
    assign rd_tag = '0;
    assign rd_valid = 1'b0;
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign o_fetch_ready = ready_ff;
  assign o_fetch_valid = valid_ff;
  assign o_fetch_err = err_ff;
  assign o_fetch_data = data_ff;
  assign o_maint_done = done_ff;
  assign o_im_read = im_read_ff;
  // line base plus the word now being requested; bit 31 stays low
  assign o_im_address = {{TOP_W{1'b0}}, addr_ff[ADDR_W-1:OFFSET_W], im_word_ff, 2'b00};
  assign o_tcm_read = tcm_read_ff;
  assign o_tcm_address = tcm_addr_ff;
  assign o_dm_address = dm_addr_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_tcm_issue;
    |o_tcm_read;
  endsequence
  sequence s_tcm_answer;
    ##2 (o_fetch_valid && !o_fetch_err);
  endsequence

  a_top_bit_low: assert property (!o_im_address[31] && !o_dm_address[31])
    else $error("address bit 31 driven high");
  a_read_per_cycle: assert property (
    (state_ff == ST_FILL && o_im_read && !i_im_waitrequest && iss_ff + 4'h1 < FILL_LEN)
    |=> (o_im_read && o_im_address[4:2] == $past(o_im_address[4:2]) + 3'h1))
    else $error("fill read not issued on the next cycle");
  a_critical_first: assert property (
    (state_ff == ST_FILL && i_im_readdatavalid && rsp_ff == 4'h0)
    |=> (o_fetch_valid && o_fetch_data == $past(i_im_readdata)))
    else $error("critical word not returned first");
  a_no_overrun: assert property (rsp_ff <= iss_ff && iss_ff <= FILL_LEN)
    else $error("fill counters out of order");
  a_tcm_bypass: assert property (
    s_tcm_issue |-> (!o_im_read && !rd_en) [*2])
    else $error("tightly-coupled fetch touched the cache");
  a_tcm_route: assert property (s_tcm_issue |-> s_tcm_answer)
    else $error("tightly-coupled fetch not answered in two cycles");
  a_maint_guard: assert property (
    (state_ff == ST_IDLE && tag_we && |maint_hit && !i_fetch_req) |-> 1'b0)
    else $error("line maintenance hit a tightly-coupled span");
  a_hit_answer: assert property (
    (state_ff == ST_LOOKUP && hit) |=> (o_fetch_valid && !o_im_read && o_fetch_ready))
    else $error("cache hit not answered next cycle");

endmodule // ifetch_mem

// file: testbench/imem_model.sv
`timescale 1ns/1ps

module imem_model
  import icache_pkg::*;
(
  // clock
  input wire logic i_clk_sys,
  // pipelined bus side
  input wire logic i_im_read,
  input wire logic [BUS_ADDR_W-1:0] i_im_address,
  output logic o_im_waitrequest,
  output logic o_im_readdatavalid,
  output logic [WORD_W-1:0] o_im_readdata,
  // tightly-coupled side, port 0 only
  input wire logic [MAX_TCM-1:0] i_tcm_read,
  input wire logic [BUS_ADDR_W-1:0] i_tcm_address,
  output logic [MAX_TCM*WORD_W-1:0] o_tcm_readdata,
  // knobs set by the bench
  input wire logic i_stall,
  input wire logic [3:0] i_lat
);
  logic [31:0] due_q[$];
  logic [31:0] adr_q[$];
  logic [31:0] cyc;

  initial begin
    cyc = 0;
    o_im_waitrequest = 1'b0;
    o_im_readdatavalid = 1'b0;
    o_im_readdata = 32'h0;
    o_tcm_readdata = '0;
  end

  // reads answered in order after i_lat cycles, more may queue meanwhile
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    o_im_waitrequest <= i_stall ? ~o_im_waitrequest : 1'b0;
    if (due_q.size() > 0 && due_q[0] <= cyc) begin
      o_im_readdatavalid <= 1'b1;
      o_im_readdata <= adr_q[0] ^ 32'h5a5a_a5a5;
      void'(due_q.pop_front());
      void'(adr_q.pop_front());
    end else begin
      o_im_readdatavalid <= 1'b0;
      o_im_readdata <= ~o_im_readdata; // stale data never looks valid
    end
    if (i_im_read && !o_im_waitrequest) begin
      due_q.push_back(cyc + i_lat);
      adr_q.push_back(i_im_address);
    end
  end

  // one memory wired straight to port 0, data one cycle after the read
  always @(posedge i_clk_sys) begin
    o_tcm_readdata <= ~o_tcm_readdata;
    if (i_tcm_read[0]) begin
      o_tcm_readdata[WORD_W-1:0] <= ~i_tcm_address;
    end
  end
endmodule // imem_model

// file: testbench/instruction_cache_tcm_fetch_tb.sv
`timescale 1ns/1ps

module instruction_cache_tcm_fetch_tb
  import icache_pkg::*;
;
  logic i_clk_sys, i_sys_rst, req, l_init, l_flush, stall, rd, wt, rdv, f_rdy, f_vld, f_err;
  logic m_done;
  logic [30:0] addr, m_addr;
  logic [31:0] rdat, f_dat, im_a, tcm_a, dm_in, dm_out, tcm_cap;
  logic [3:0] lat, tcm_rd;
  logic [127:0] tcm_dat;
  logic [31:0] rd_q[$];
  int num_errors, compares, rdv_n, early_n, tcm_n;
  localparam logic [30:0] A = 31'h0000_0134;
  localparam logic [30:0] B = 31'h4000_0134;
  localparam logic [30:0] T = 31'h0001_0124;

  ifetch_mem #(.CACHE_BYTES(512), .NUM_TCM(1), .TCM_BASE(128'h1_0000),
    .TCM_SPAN(128'h1000)) dut_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_fetch_req(req), .i_fetch_addr(addr), .o_fetch_ready(f_rdy),
    .o_fetch_valid(f_vld), .o_fetch_err(f_err), .o_fetch_data(f_dat),
    .i_line_init(l_init), .i_line_flush(l_flush), .i_maint_addr(m_addr),
    .o_maint_done(m_done), .o_im_read(rd), .o_im_address(im_a),
    .i_im_waitrequest(wt), .i_im_readdatavalid(rdv), .i_im_readdata(rdat),
    .o_tcm_read(tcm_rd), .o_tcm_address(tcm_a), .i_tcm_readdata(tcm_dat),
    .i_dm_addr(dm_in), .o_dm_address(dm_out));

  imem_model mem_u (.i_clk_sys(i_clk_sys), .i_im_read(rd), .i_im_address(im_a),
    .o_im_waitrequest(wt), .o_im_readdatavalid(rdv), .o_im_readdata(rdat),
    .i_tcm_read(tcm_rd), .i_tcm_address(tcm_a), .o_tcm_readdata(tcm_dat),
    .i_stall(stall), .i_lat(lat));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // records accepted bus reads and tightly-coupled reads
  always @(posedge i_clk_sys) begin
    if (rd && !wt) begin
      rd_q.push_back(im_a);
      if (rdv_n == 0) early_n++;
    end
    if (rdv) rdv_n++;
    if (tcm_rd !== 4'h0) begin
      tcm_n++;
      tcm_cap = tcm_a;
    end
  end

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] bw(input logic [30:0] a);
    return {1'b0, a[30:2], 2'b00} ^ 32'h5a5a_a5a5;
  endfunction

  task automatic clr;
    rd_q.delete();
    rdv_n = 0;
    early_n = 0;
    tcm_n = 0;
  endtask

  // bounded wait; a hang goes straight to the report
  task automatic wait_ready;
    int n;
    n = 0;
    while (f_rdy !== 1'b1) begin
      @(posedge i_clk_sys);
      #1;
      n++;
      if (n > 200) begin
        num_errors++;
        finish_test();
      end
    end
  endtask

  // lat 0 means the answer time is not judged (misses)
  task automatic fetch(input logic [30:0] a, input logic [31:0] exp, input int lt);
    int n;
    wait_ready();
    req = 1'b1;
    addr = a;
    @(posedge i_clk_sys);
    #1;
    req = 1'b0;
    n = 1;
    while (f_vld !== 1'b1) begin
      @(posedge i_clk_sys);
      #1;
      n++;
      if (n > 200) begin
        num_errors++;
        finish_test();
      end
    end
    chk(f_err, 0);
    chk(f_dat, exp);
    if (lt != 0) chk(n, lt);
  endtask

  // whole line fetched, critical word first, wrapping, bit 31 clear
  task automatic line_chk(input logic [30:0] a);
    wait_ready();
    chk(rd_q.size(), 8);
    for (int k = 0; k < 8; k++) begin
      chk(rd_q[k], {1'b0, a[30:5], 5'h0} | 32'(((a[4:2] + k) % 8) * 4));
    end
  endtask

  task automatic maint(input logic [30:0] a, input logic fl);
    wait_ready();
    l_init = !fl;
    l_flush = fl;
    m_addr = a;
    @(posedge i_clk_sys);
    #1;
    l_init = 1'b0;
    l_flush = 1'b0;
    chk(m_done, 1);
    // let an edge pass so a following strobe never rises in this time step
    @(posedge i_clk_sys);
    #1;
    chk(m_done, 0);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_miss;
    clr();
    fetch(A, bw(A), 0);
    line_chk(A);
    chk(early_n >= 2, 1);
    chk(tcm_n, 0);
  endtask

  task automatic t_hit;
    clr();
    for (int w = 0; w < 8; w++) begin
      fetch({A[30:5], 3'(w), 2'b00}, bw({A[30:5], 3'(w), 2'b00}), 2);
    end
    chk(rd_q.size(), 0);
  endtask

  // same index, tags differ in bit 30 or bit 9: each evicts the one before
  task automatic t_conflict;
    clr();
    fetch(B, bw(B), 0);
    line_chk(B);
    clr();
    fetch(A + 31'h200, bw(A + 31'h200), 0);
    line_chk(A + 31'h200);
    clr();
    fetch(A, bw(A), 0);
    line_chk(A);
  endtask

  task automatic t_stall;
    stall = 1'b1;
    lat = 4'h1;
    clr();
    fetch(31'h0000_0208, bw(31'h0000_0208), 0);
    line_chk(31'h0000_0208);
    stall = 1'b0;
    lat = 4'h4;
  endtask

  // tight span bypasses the cache; maintenance there spares the line
  task automatic t_tcm;
    clr();
    fetch(T, ~{1'b0, T[30:2], 2'b00}, 3);
    chk(tcm_n, 1);
    chk(tcm_cap, {1'b0, T[30:2], 2'b00});
    chk(rd_q.size(), 0);
    maint(T, 1'b0);
    maint(T, 1'b1);
    fetch(A, bw(A), 2);
    chk(rd_q.size(), 0);
    maint(A, 1'b1);
    fetch(A, bw(A), 0);
    line_chk(A);
    maint(A, 1'b0);
    clr();
    fetch(A, bw(A), 0);
    line_chk(A);
  endtask

  task automatic t_dm;
    dm_in = 32'hffff_fff0;
    @(posedge i_clk_sys);
    #1;
    chk(dm_out, 32'h7fff_fff0);
    dm_in = 32'h8000_0004;
    @(posedge i_clk_sys);
    #1;
    chk(dm_out, 32'h0000_0004);
  endtask

  // a second reset in mid-run must drop the cached line of A
  task automatic t_rst;
    i_sys_rst = 1'b1;
    @(posedge i_clk_sys);
    #1;
    chk({f_vld, rd, m_done, f_rdy}, 0);
    i_sys_rst = 1'b0;
    clr();
    fetch(A, bw(A), 0);
    line_chk(A);
  endtask

  // main sequence
  initial begin
    num_errors = 0;
    compares = 0;
    i_sys_rst = 1'b1;
    req = 1'b0;
    addr = 31'h0;
    l_init = 1'b0;
    l_flush = 1'b0;
    m_addr = 31'h0;
    stall = 1'b0;
    lat = 4'h4;
    dm_in = 32'h0;
    clr();
    repeat (10) @(posedge i_clk_sys);
    #1;
    chk({f_rdy, f_vld, rd, m_done}, 0);
    i_sys_rst = 1'b0;
    t_miss();
    t_hit();
    t_conflict();
    t_stall();
    t_tcm();
    t_dm();
    t_rst();
    finish_test();
  end
endmodule // instruction_cache_tcm_fetch_tb
